// >>> logic/ipr_defs.svh
`ifndef IPR_DEFS_SVH
`define IPR_DEFS_SVH

// ***************************
// register byte offsets
// ***************************
`define IPR_OFS_T6_DMA4_OC8 12'h000
`define IPR_OFS_T8_I2C2_T7 12'h004

// ***************************
// field positions (low bit of each 3-bit field)
// ***************************
`define IPR_FLD_W 3
`define IPR_POS_TIMER6 12
`define IPR_POS_DMA4 8
`define IPR_POS_OC8 0
`define IPR_POS_TIMER8 12
`define IPR_POS_I2C2_MST 8
`define IPR_POS_I2C2_SLV 4
`define IPR_POS_TIMER7 0

// ***************************
// reset value and disable code
// ***************************
`define IPR_PRIO_RESET 3'h4
`define IPR_PRIO_OFF 3'h0

// ***************************
// axi responses
// ***************************
`define IPR_RESP_OKAY 2'h0
`define IPR_RESP_SLVERR 2'h2

`endif

// >>> logic/ipr_pkg.sv
package ipr_pkg;
   typedef logic [2:0] ipr_prio_type;
   typedef enum logic [1:0] {IPR_IDLE, IPR_RESP} ipr_chan_type;
endpackage

// >>> logic/ipr_regs.sv
// Behaviour
// R1: three-bit field, 7 highest, 1 lowest
// R2: code 000 disables the source
// R3: unassigned bits read zero, ignore writes
// R4: first register 14-12 timer 6
// R5: first register 10-8 dma channel 4 done
// R6: first register 7-3 unused, 2-0 compare 8
// R7: second register 14-12, 10-8, 2-0 fields
// R8: second register 6-4 i2c slave, gaps unused
// R9: every field resets to level 4
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`include "ipr_defs.svh"

module ipr_regs #(
   parameter int ADDR_W = 12
) (
   // clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // write address
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // read address
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // priority levels, each with its enable
   output ipr_pkg::ipr_prio_type timer6_prio,
   output ipr_pkg::ipr_prio_type dma_ch4_done_prio,
   output ipr_pkg::ipr_prio_type out_compare8_prio,
   output ipr_pkg::ipr_prio_type timer8_prio,
   output ipr_pkg::ipr_prio_type i2c_port2_master_prio,
   output ipr_pkg::ipr_prio_type i2c_port2_slave_prio,
   output ipr_pkg::ipr_prio_type timer7_prio,
   output logic [6:0] src_enable
);

   // the word index needs address bits above bit 1
   if (ADDR_W < 3) begin : g_addr_w_check
      $error("ADDR_W too small");
   end

   // ***************************
   // helpers
   // ***************************
   // byte-lane merge of one 3-bit field at a given low bit
   function automatic ipr_pkg::ipr_prio_type merge_fld(input ipr_pkg::ipr_prio_type old,
         input logic [31:0] data, input logic [3:0] strb, input int pos);
      logic [15:0] w;
      w = {13'h0000, old} << pos;
      if (strb[pos/8]) w = data[15:0];
      return w[pos +: `IPR_FLD_W];
   endfunction

   // nonzero code means the source may be presented
   function automatic logic prio_on(input ipr_pkg::ipr_prio_type p);
      return p != `IPR_PRIO_OFF; // R2
   endfunction

   // word decode: byte lane bits below bit 2 are ignored
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
         input logic [ADDR_W-1:0] ofs);
      return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
   endfunction

   // ***************************
   // state
   // ***************************
   ipr_pkg::ipr_chan_type wr_q, wr_d, rd_q, rd_d;
   logic aw_got_q, aw_got_d, w_got_q, w_got_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
   logic [3:0] wstrb_q, wstrb_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   ipr_pkg::ipr_prio_type t6_q, t6_d, dma4_q, dma4_d, oc8_q, oc8_d;
   ipr_pkg::ipr_prio_type t8_q, t8_d, mst_q, mst_d, slv_q, slv_d, t7_q, t7_d;
   logic [6:0] en_q, en_d;
   logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
   logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   logic [15:0] reg0_v, reg1_v;

   // R3 R4 R5 R6 R7 R8: register images, unassigned bits tied low
   always_comb begin
      reg0_v = '0;
      reg0_v[`IPR_POS_TIMER6 +: `IPR_FLD_W] = t6_q; // R4
      reg0_v[`IPR_POS_DMA4 +: `IPR_FLD_W] = dma4_q; // R5
      reg0_v[`IPR_POS_OC8 +: `IPR_FLD_W] = oc8_q; // R6
      reg1_v = '0;
      reg1_v[`IPR_POS_TIMER8 +: `IPR_FLD_W] = t8_q; // R7
      reg1_v[`IPR_POS_I2C2_MST +: `IPR_FLD_W] = mst_q; // R7
      reg1_v[`IPR_POS_I2C2_SLV +: `IPR_FLD_W] = slv_q; // R8
      reg1_v[`IPR_POS_TIMER7 +: `IPR_FLD_W] = t7_q; // R7
   end

   // ***************************
   // write channel and field storage
   // ***************************
   always_comb begin
      wr_d = wr_q;
      aw_got_d = aw_got_q;
      w_got_d = w_got_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb_d = wstrb_q;
      bresp_d = bresp_q;
      t6_d = t6_q;
      dma4_d = dma4_q;
      oc8_d = oc8_q;
      t8_d = t8_q;
      mst_d = mst_q;
      slv_d = slv_q;
      t7_d = t7_q;
      unique case (wr_q)
         ipr_pkg::IPR_IDLE: begin
            if (s_axi_awvalid && awready_q) begin
               aw_got_d = 1'b1;
               awaddr_d = s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_q) begin
               w_got_d = 1'b1;
               wdata_d = s_axi_wdata;
               wstrb_d = s_axi_wstrb;
            end
            if (aw_got_q && w_got_q) begin
               // only field bits are stored; other bits are dropped here
               bresp_d = `IPR_RESP_OKAY;
               if (addr_is(awaddr_q, ADDR_W'(`IPR_OFS_T6_DMA4_OC8))) begin
                  t6_d = merge_fld(t6_q, wdata_q, wstrb_q, `IPR_POS_TIMER6); // R4
                  dma4_d = merge_fld(dma4_q, wdata_q, wstrb_q, `IPR_POS_DMA4); // R5
                  oc8_d = merge_fld(oc8_q, wdata_q, wstrb_q, `IPR_POS_OC8); // R6
               end else if (addr_is(awaddr_q, ADDR_W'(`IPR_OFS_T8_I2C2_T7))) begin
                  t8_d = merge_fld(t8_q, wdata_q, wstrb_q, `IPR_POS_TIMER8); // R7
                  mst_d = merge_fld(mst_q, wdata_q, wstrb_q, `IPR_POS_I2C2_MST); // R7
                  slv_d = merge_fld(slv_q, wdata_q, wstrb_q, `IPR_POS_I2C2_SLV); // R8
                  t7_d = merge_fld(t7_q, wdata_q, wstrb_q, `IPR_POS_TIMER7); // R7
               end else begin
                  bresp_d = `IPR_RESP_SLVERR;
               end
               aw_got_d = 1'b0;
               w_got_d = 1'b0;
               wr_d = ipr_pkg::IPR_RESP;
            end
         end
         ipr_pkg::IPR_RESP: begin
            if (s_axi_bready) wr_d = ipr_pkg::IPR_IDLE;
         end
      endcase
      // ready only while nothing is held, so a held valid is never taken twice
      awready_d = wr_d == ipr_pkg::IPR_IDLE && !aw_got_d;
      wready_d = wr_d == ipr_pkg::IPR_IDLE && !w_got_d;
      bvalid_d = wr_d == ipr_pkg::IPR_RESP;
   end

   // ***************************
   // read channel
   // ***************************
   always_comb begin
      rd_d = rd_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      unique case (rd_q)
         ipr_pkg::IPR_IDLE: begin
            if (s_axi_arvalid && arready_q) begin
               rd_d = ipr_pkg::IPR_RESP;
               rresp_d = `IPR_RESP_OKAY;
               rdata_d = '0; // R3
               if (addr_is(s_axi_araddr, ADDR_W'(`IPR_OFS_T6_DMA4_OC8)))
                  rdata_d = {16'h0000, reg0_v};
               else if (addr_is(s_axi_araddr, ADDR_W'(`IPR_OFS_T8_I2C2_T7)))
                  rdata_d = {16'h0000, reg1_v};
               else
                  rresp_d = `IPR_RESP_SLVERR;
            end
         end
         ipr_pkg::IPR_RESP: begin
            if (s_axi_rready) rd_d = ipr_pkg::IPR_IDLE;
         end
      endcase
      arready_d = rd_d == ipr_pkg::IPR_IDLE;
      rvalid_d = rd_d == ipr_pkg::IPR_RESP;
   end

   // R1 R2: field value passes through as the level, zero gates the source
   always_comb begin
      en_d = {prio_on(t6_d), prio_on(dma4_d), prio_on(oc8_d), prio_on(t8_d),
            prio_on(mst_d), prio_on(slv_d), prio_on(t7_d)};
   end

   // ***************************
   // registers
   // ***************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_q <= ipr_pkg::IPR_IDLE;
         rd_q <= ipr_pkg::IPR_IDLE;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         bresp_q <= `IPR_RESP_OKAY;
         rdata_q <= '0;
         rresp_q <= `IPR_RESP_OKAY;
         t6_q <= `IPR_PRIO_RESET; // R9
         dma4_q <= `IPR_PRIO_RESET; // R9
         oc8_q <= `IPR_PRIO_RESET; // R9
         t8_q <= `IPR_PRIO_RESET; // R9
         mst_q <= `IPR_PRIO_RESET; // R9
         slv_q <= `IPR_PRIO_RESET; // R9
         t7_q <= `IPR_PRIO_RESET; // R9
         en_q <= '1;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         arready_q <= 1'b0;
         bvalid_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else if (clk_en) begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         aw_got_q <= aw_got_d;
         w_got_q <= w_got_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb_q <= wstrb_d;
         bresp_q <= bresp_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
         t6_q <= t6_d;
         dma4_q <= dma4_d;
         oc8_q <= oc8_d;
         t8_q <= t8_d;
         mst_q <= mst_d;
         slv_q <= slv_d;
         t7_q <= t7_d;
         en_q <= en_d;
         // limitation: readies freeze too, so the bus must stay quiet while clk_en is low
         awready_q <= awready_d;
         wready_q <= wready_d;
         arready_q <= arready_d;
         bvalid_q <= bvalid_d;
         rvalid_q <= rvalid_d;
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_arready = arready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign timer6_prio = t6_q;
   assign dma_ch4_done_prio = dma4_q;
   assign out_compare8_prio = oc8_q;
   assign timer8_prio = t8_q;
   assign i2c_port2_master_prio = mst_q;
   assign i2c_port2_slave_prio = slv_q;
   assign timer7_prio = t7_q;
   assign src_enable = en_q; // R2

endmodule

// >>> tb/ipr_regs_checker.sv
module ipr_regs_checker (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // levels
   input wire ipr_pkg::ipr_prio_type timer6_prio,
   input wire ipr_pkg::ipr_prio_type dma_ch4_done_prio,
   input wire ipr_pkg::ipr_prio_type out_compare8_prio,
   input wire ipr_pkg::ipr_prio_type timer8_prio,
   input wire ipr_pkg::ipr_prio_type i2c_port2_master_prio,
   input wire ipr_pkg::ipr_prio_type i2c_port2_slave_prio,
   input wire ipr_pkg::ipr_prio_type timer7_prio,
   input wire logic [6:0] src_enable
);
   timeunit 1ns;
   timeprecision 100ps;
   // ***************
   // properties
   // ***************
   wire logic [20:0] all_prio = {timer6_prio, dma_ch4_done_prio, out_compare8_prio, timer8_prio,
      i2c_port2_master_prio, i2c_port2_slave_prio, timer7_prio};
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_enable_map: assert property (
      src_enable == {|timer6_prio, |dma_ch4_done_prio, |out_compare8_prio, |timer8_prio,
      |i2c_port2_master_prio, |i2c_port2_slave_prio, |timer7_prio}) else $error("enable map");
   chk_reset_level: assert property (
      $rose(aresetn) |-> all_prio == {7{3'h4}}) else $error("reset level");
   chk_rvalid_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("rvalid dropped");
   chk_bvalid_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
   chk_rvalid_drop: assert property (
      s_axi_rvalid && s_axi_rready && clk_en |=> !s_axi_rvalid) else $error("rvalid stuck");
   chk_read_answer: assert property (
      s_axi_arvalid && !s_axi_rvalid && clk_en |-> ##[1:2] s_axi_rvalid) else $error("no rvalid");
   chk_store_quiet: assert property (
      $changed(all_prio) |-> s_axi_bvalid) else $error("level moved without write");
   chk_freeze_hold: assert property (
      !clk_en |=> $stable(all_prio) && $stable(src_enable) && $stable(s_axi_rvalid)
      && $stable(s_axi_bvalid)) else $error("state moved while frozen");
   chk_gap_bits: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:15] == 17'h0 && !s_axi_rdata[11] && !s_axi_rdata[3])
      else $error("gap bit set");
endmodule

// >>> tb/tb.sv
`include "ipr_defs.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; \
   $display("BAD %0t got %h exp %h", $time, (a), (b)); end end

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk, aresetn = 1'b0, clk_en = 1'b1;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0, rdata, rdat;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [15:0] v;
   ipr_pkg::ipr_prio_type p6, pd, po, p8, pm, ps, p7;
   logic [6:0] src_enable;
   int error_cnt = 0;
   int checked = 0;
   ipr_regs DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .timer6_prio(p6), .dma_ch4_done_prio(pd), .out_compare8_prio(po),
      .timer8_prio(p8), .i2c_port2_master_prio(pm), .i2c_port2_slave_prio(ps),
      .timer7_prio(p7), .src_enable(src_enable));
   // ***************
   // bus tasks
   // ***************
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rdat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   task automatic report_and_stop();
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ***************
   // tests
   // ***************
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   initial begin
      #100us;
      error_cnt++;
      report_and_stop();
   end
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`IPR_OFS_T6_DMA4_OC8);
      `CHK(rdat, 32'h0000_4404)
      rd(`IPR_OFS_T8_I2C2_T7);
      `CHK(rdat, 32'h0000_4444)
      wr(`IPR_OFS_T6_DMA4_OC8, 32'hffff_ffff, 4'hf);
      rd(`IPR_OFS_T6_DMA4_OC8);
      `CHK(rdat, 32'h0000_7707)
      `CHK({p6, pd, po}, 9'h1ff)
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0], 1'b0, c[2:0]};
         wr(`IPR_OFS_T8_I2C2_T7, {16'hffff, v | 16'h8888}, 4'hf);
         rd(`IPR_OFS_T8_I2C2_T7);
         `CHK(rdat, {16'h0, v})
         `CHK({p8, pm, ps, p7}, {4{c[2:0]}})
         `CHK(src_enable[3:0], {4{c != 0}})
      end
      clk_en <= 1'b0;
      repeat (3) @(posedge aclk);
      `CHK({p8, src_enable[3:0]}, {3'h7, 4'hf})
      clk_en <= 1'b1;
      wr(`IPR_OFS_T6_DMA4_OC8, 32'h0, 4'h1);
      `CHK({resp, p6, pd, po, src_enable[4]}, {`IPR_RESP_OKAY, 9'h1f8, 1'b0})
      wr(12'h008, 32'h0, 4'hf);
      `CHK({resp, p6}, {`IPR_RESP_SLVERR, 3'h7})
      rd(12'h008);
      `CHK({resp, rdat}, {`IPR_RESP_SLVERR, 32'h0})
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK({p6, p7, src_enable}, {3'h4, 3'h4, 7'h7f})
      rd(`IPR_OFS_T8_I2C2_T7);
      `CHK({resp, rdat}, {`IPR_RESP_OKAY, 32'h0000_4444})
      report_and_stop();
   end
endmodule

bind ipr_regs ipr_regs_checker chk (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .timer6_prio(timer6_prio), .dma_ch4_done_prio(dma_ch4_done_prio),
   .out_compare8_prio(out_compare8_prio), .timer8_prio(timer8_prio),
   .i2c_port2_master_prio(i2c_port2_master_prio), .i2c_port2_slave_prio(i2c_port2_slave_prio),
   .timer7_prio(timer7_prio), .src_enable(src_enable));
